// *** logic/pdc_defines.svh ***
/*
  Constants for the power-down pin state control block.
  Assumes inclusion by bare name from files under logic/.
*/
// Behaviour
// - In sleep or halt, memory read strobe driven high when routed to pin.
// - In sleep or halt, memory write strobe driven high when routed to pin.
// - Boot and work memory selects forced high throughout sleep or halt.
// - Peripheral select tri-stated in sleep or halt when routed to its pin.
// - Processor read and write strobes high impedance in sleep or halt.
// - All twenty address outputs high impedance in power-down, shared pin included.
// - All eight data lines released to high impedance in power-down.
// - Host-UART emulation logic held disabled during any power-down mode.
// - Reset pin resets configuration, boundaries, serial, ports, UART emulation.
// - Normal mode stretches reset by one-shot; adapter mode bypasses it.
// - Core crystal oscillator disabled in adapter or probe mode.
// - After reset serial controller clock is undivided, ratio one.
`ifndef PDC_DEFINES_SVH
`define PDC_DEFINES_SVH
`define PDC_ADDR_W       20
`define PDC_DATA_W       8
`define PDC_FSEL_W       3
`define PDC_FSEL_RDSTB   0
`define PDC_FSEL_WRSTB   1
`define PDC_FSEL_PERIPH  2
`define PDC_STRETCH_NS   1000
`define PDC_CLK_MHZ      125
`define PDC_STRETCH_CYC  ((`PDC_STRETCH_NS * `PDC_CLK_MHZ + 999) / 1000)
`define PDC_CNT_W        8
`define PDC_DIV_RESET    1'h0
`define PDC_STROBE_IDLE  1'h1
`define PDC_OE_RESET     1'h0
`define PDC_ADDR_RESET   20'h00000
`define PDC_DATA_RESET   8'h00
`define PDC_RSTREQ_RESET 1'h1
`define PDC_INTRST_RESET 1'h1
`define PDC_UART_RESET   1'h0
`define PDC_OSC_RESET    1'h1
`define PDC_MODE_RESET   2'h0
`endif

// *** logic/pdc_pkg.sv ***
/*
  Types for the power-down pin state control block.
  Assumes nothing beyond the defines header.
*/
`default_nettype none
package pdc_pkg;
  typedef enum logic [1:0] {PDC_NORMAL, PDC_ADAPTER, PDC_PROBE, PDC_TEST} pdc_mode_e;
  typedef enum logic [0:0] {PDC_IDLE, PDC_STRETCH} pdc_rst_e;
endpackage
`default_nettype wire

// *** logic/pdc_reset_stretch.sv ***
/*
  Reset one-shot stretcher with adapter-mode bypass.
  Assumes the reset request is already synchronised to clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pdc_defines.svh"
module pdc_reset_stretch (
  // clock and reset
  input  wire logic clock,
  input  wire logic rstn,
  // control
  input  wire logic resetReqSync,
  input  wire logic bypass,
  // result
  output logic      intReset
);
  pdc_pkg::pdc_rst_e          state;
  logic [`PDC_CNT_W-1:0]      count;
  wire                        done = (count == `PDC_CNT_W'(`PDC_STRETCH_CYC - 1));

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      state    <= pdc_pkg::PDC_STRETCH;
      count    <= '0;
      intReset <= `PDC_INTRST_RESET;
    end
    else
    begin
      case (state)
        pdc_pkg::PDC_IDLE:
        begin
          count    <= '0;
          intReset <= resetReqSync;
          if (resetReqSync && !bypass)
            state <= pdc_pkg::PDC_STRETCH;
        end
        pdc_pkg::PDC_STRETCH:
        begin
          intReset <= 1'h1;
          count    <= count + 1'h1;
          // one-shot: full duration even for a short pin pulse
          if (bypass || (done && !resetReqSync))
          begin
            state    <= pdc_pkg::PDC_IDLE;
            intReset <= resetReqSync;
          end
          else if (done)
            count <= count;
        end
        default: state <= pdc_pkg::PDC_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** logic/pdc_pin_control.sv ***
/*
  Power-down pin state control: sleep/halt overrides of bus pins,
  reset conditioning, oscillator gating, serial clock divide.
  Assumes core-side signals on clock; mode pins and reset pin asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pdc_defines.svh"
module pdc_pin_control (
  // clock and reset
  input  wire logic                   clock,
  input  wire logic                   rstn,
  // external pins sampled here
  input  wire logic                   resetPinN,
  input  wire logic                   emul_select_lo,
  input  wire logic                   emul_select_hi,
  // core state
  input  wire logic                   coreSleep,
  input  wire logic                   coreHalt,
  input  wire logic [`PDC_FSEL_W-1:0] pin_function_select_reg,
  input  wire logic                   serialDivTwo,
  // core normal pin values
  input  wire logic                   coreMemReadN,
  input  wire logic                   coreMemWriteN,
  input  wire logic                   coreBootSelN,
  input  wire logic                   coreWorkSelN,
  input  wire logic                   corePeriphSelN,
  input  wire logic                   coreRdN,
  input  wire logic                   coreWrN,
  input  wire logic [`PDC_ADDR_W-1:0] coreAddr,
  input  wire logic [`PDC_DATA_W-1:0] coreDataOut,
  input  wire logic                   coreDataOe,
  // pins
  output logic                        memory_read_strobe_n,
  output logic                        memory_write_strobe_n,
  output logic                        boot_memory_select_n,
  output logic                        work_memory_select_n,
  output logic                        peripheral_select_n,
  output logic                        peripheral_select_oe,
  output logic                        readStrobeN,
  output logic                        writeStrobeN,
  output logic                        strobeOe,
  output logic [`PDC_ADDR_W-1:0]      addrOut,
  output logic                        addrOe,
  output logic [`PDC_DATA_W-1:0]      dataOut,
  output logic                        dataOe,
  // system controls
  output logic                        internalReset,
  output logic                        uartEmulEnable,
  output logic                        oscEnable,
  output logic                        serialClkDivTwo,
  output logic [1:0]                  emulMode
);
  logic       rstMeta;
  logic       rstSync;
  logic [1:0] modeMeta;
  logic [1:0] modeSync;
  logic       intReset;

  // override high only while powered down and the function owns the pin
  function automatic logic forceHigh(input logic down, input logic owned, input logic normal);
    forceHigh = (down && owned) ? 1'h1 : normal;
  endfunction

  // enable drops only while powered down and the function owns the pin
  function automatic logic keepDriving(input logic down, input logic owned);
    keepDriving = ~(down && owned);
  endfunction

  // raw select pins against one mode
  function automatic logic modeIs(input logic [1:0] raw, input pdc_pkg::pdc_mode_e want);
    modeIs = (pdc_pkg::pdc_mode_e'(raw) == want);
  endfunction

  // reset request asserted during rstn so the stretcher cannot start late
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      rstMeta <= `PDC_RSTREQ_RESET;
      rstSync <= `PDC_RSTREQ_RESET;
    end
    else
    begin
      rstMeta <= ~resetPinN;
      rstSync <= rstMeta;
    end
  end

  // select pins are levels; two flops keep metastability out of the decode
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      modeMeta <= `PDC_MODE_RESET;
      modeSync <= `PDC_MODE_RESET;
    end
    else
    begin
      modeMeta <= {emul_select_hi, emul_select_lo};
      modeSync <= modeMeta;
    end
  end

  // test encoding gets no decode of its own: behaves as normal
  wire isAdapter = modeIs(modeSync, pdc_pkg::PDC_ADAPTER);
  wire isProbe   = modeIs(modeSync, pdc_pkg::PDC_PROBE);

  pdc_reset_stretch u_stretch (
    .clock        (clock),
    .rstn         (rstn),
    .resetReqSync (rstSync),
    .bypass       (isAdapter),
    .intReset     (intReset)
  );

  // core signals are same-domain: override follows entry/exit directly
  wire powerDown   = coreSleep | coreHalt;
  wire selMemRead  = pin_function_select_reg[`PDC_FSEL_RDSTB];
  wire selMemWrite = pin_function_select_reg[`PDC_FSEL_WRSTB];
  wire selPeriph   = pin_function_select_reg[`PDC_FSEL_PERIPH];

  wire next_memRead  = forceHigh(powerDown, selMemRead, coreMemReadN);
  wire next_memWrite = forceHigh(powerDown, selMemWrite, coreMemWriteN);
  wire next_boot     = forceHigh(powerDown, 1'h1, coreBootSelN);
  wire next_work     = forceHigh(powerDown, 1'h1, coreWorkSelN);
  wire next_periphOe = keepDriving(powerDown, selPeriph);
  wire next_strOe    = keepDriving(powerDown, 1'h1);
  wire next_addrOe   = keepDriving(powerDown, 1'h1);
  wire next_dataOe   = coreDataOe & keepDriving(powerDown, 1'h1);
  wire next_uart     = ~powerDown & ~intReset;
  wire next_osc      = ~(isAdapter | isProbe);
  // divider returns to one on every internal reset
  wire next_div      = intReset ? `PDC_DIV_RESET : serialDivTwo;

  // memory strobes idle high while held in reset
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      memory_read_strobe_n  <= `PDC_STROBE_IDLE;
      memory_write_strobe_n <= `PDC_STROBE_IDLE;
    end
    else
    begin
      memory_read_strobe_n  <= next_memRead;
      memory_write_strobe_n <= next_memWrite;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      boot_memory_select_n <= `PDC_STROBE_IDLE;
      work_memory_select_n <= `PDC_STROBE_IDLE;
    end
    else
    begin
      boot_memory_select_n <= next_boot;
      work_memory_select_n <= next_work;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      peripheral_select_n  <= `PDC_STROBE_IDLE;
      peripheral_select_oe <= `PDC_OE_RESET;
    end
    else
    begin
      peripheral_select_n  <= corePeriphSelN;
      peripheral_select_oe <= next_periphOe;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      readStrobeN  <= `PDC_STROBE_IDLE;
      writeStrobeN <= `PDC_STROBE_IDLE;
      strobeOe     <= `PDC_OE_RESET;
    end
    else
    begin
      readStrobeN  <= coreRdN;
      writeStrobeN <= coreWrN;
      strobeOe     <= next_strOe;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      addrOut <= `PDC_ADDR_RESET;
      addrOe  <= `PDC_OE_RESET;
    end
    else
    begin
      addrOut <= coreAddr;
      addrOe  <= next_addrOe;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      dataOut <= `PDC_DATA_RESET;
      dataOe  <= `PDC_OE_RESET;
    end
    else
    begin
      dataOut <= coreDataOut;
      dataOe  <= next_dataOe;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      internalReset  <= `PDC_INTRST_RESET;
      uartEmulEnable <= `PDC_UART_RESET;
    end
    else
    begin
      internalReset  <= intReset;
      uartEmulEnable <= next_uart;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      oscEnable <= `PDC_OSC_RESET;
      emulMode  <= `PDC_MODE_RESET;
    end
    else
    begin
      oscEnable <= next_osc;
      emulMode  <= modeSync;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
      serialClkDivTwo <= `PDC_DIV_RESET;
    else
      serialClkDivTwo <= next_div;
  end
endmodule
`default_nettype wire

// *** bench/pdc_pin_checker.sv ***
/*
  Assertions on the power-down pin overrides.
  Bound into pdc_pin_control; sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module pdc_pin_checker (
  // clock and reset
  input wire logic       clock,
  input wire logic       rstn,
  // causes
  input wire logic       coreSleep,
  input wire logic       coreHalt,
  input wire logic [2:0] pin_function_select_reg,
  input wire logic [1:0] emulMode,
  // effects
  input wire logic       memory_read_strobe_n,
  input wire logic       memory_write_strobe_n,
  input wire logic       boot_memory_select_n,
  input wire logic       work_memory_select_n,
  input wire logic       peripheral_select_oe,
  input wire logic       strobeOe,
  input wire logic       addrOe,
  input wire logic       dataOe,
  input wire logic       uartEmulEnable,
  input wire logic       oscEnable
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  wire pd = coreSleep | coreHalt;
  // emulation mode held for two samples
  sequence emulSettled;
    (emulMode == 2'h1 || emulMode == 2'h2)[*2];
  endsequence
  rd_wr_high_a: assert property (pd && pin_function_select_reg[0] |=> memory_read_strobe_n
    && (!$past(pin_function_select_reg[1]) || memory_write_strobe_n)) else $error("strobe low");
  sel_high_a: assert property (pd |=> boot_memory_select_n && work_memory_select_n)
    else $error("select low");
  periph_off_a: assert property (pd && pin_function_select_reg[2] |=> !peripheral_select_oe)
    else $error("periph driven");
  periph_on_a: assert property (rstn && (!pd || !pin_function_select_reg[2])
    |=> peripheral_select_oe) else $error("periph off");
  strobe_off_a: assert property (pd |=> !strobeOe) else $error("strobes driven");
  bus_off_a: assert property (pd |=> !addrOe ##0 !dataOe) else $error("bus driven");
  uart_off_a: assert property (pd |=> !uartEmulEnable) else $error("uart on");
  osc_off_a: assert property (emulSettled |-> !oscEnable) else $error("osc on");
endmodule
bind pdc_pin_control pdc_pin_checker u_pdc_pin_checker (.*);
`default_nettype wire

// *** bench/pdc_far_side.sv ***
/*
  Far-side model: memories and I/O see address and data resolved from enables.
  Assumes pin values and enables of pdc_pin_control.
*/
`timescale 1ns/1ps
`default_nettype none
module pdc_far_side (
  // pins
  input  wire logic [19:0] addrOut,
  input  wire logic        addrOe,
  input  wire logic [7:0]  dataOut,
  input  wire logic        dataOe,
  input  wire logic [1:0]  emulMode,
  // seen on the board
  output wire logic [19:0] addrBus,
  output wire logic [7:0]  dataBus
);
  // no pull: a released line must not keep showing the last value
  // adapter mode: the emulator, not this device, puts bit 18 on a released bus
  localparam logic [19:0] EMUL_ADDR = 20'h40000;
  assign addrBus = addrOe ? addrOut : (emulMode == 2'h1) ? EMUL_ADDR : ~addrOut;
  assign dataBus = dataOe ? dataOut : ~dataOut;
endmodule
`default_nettype wire

// *** bench/pdc_pin_control_tb_top.sv ***
/*
  Self-checking bench for pdc_pin_control with far-side model.
  Assumes 125 MHz clock and synchronous active-low rstn.
*/
`timescale 1ns/1ps
`default_nettype none
module pdc_pin_control_tb_top;
  logic clock, rstn, resetPinN, emul_select_lo, emul_select_hi, coreSleep, coreHalt;
  logic serialDivTwo, coreMemReadN, coreMemWriteN, coreBootSelN, coreWorkSelN;
  logic corePeriphSelN, coreRdN, coreWrN, coreDataOe, addrOe, dataOe, strobeOe;
  logic memory_read_strobe_n, memory_write_strobe_n, boot_memory_select_n;
  logic work_memory_select_n, peripheral_select_n, peripheral_select_oe;
  logic readStrobeN, writeStrobeN, internalReset, uartEmulEnable, oscEnable, serialClkDivTwo;
  logic [2:0]  pin_function_select_reg;
  logic [1:0]  emulMode;
  logic [19:0] coreAddr, addrOut, addrBus;
  logic [7:0]  coreDataOut, dataOut, dataBus;
  int errors = 0;
  int n_compared = 0;
  pdc_pin_control u_pdc_pin_control (.*);
  pdc_far_side u_pdc_far_side (.*);
  task automatic chk(string what, logic [19:0] seen, logic [19:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic waitIdle(int bound);
    for (int i = 0; i < bound && internalReset !== 1'h0; i++)
      tick(1);
    if (internalReset !== 1'h0)
    begin
      errors++;
      report_and_stop();
    end
  endtask
  initial
  begin
    clock = 1'h0;
    forever #4 clock = ~clock;
  end
  initial
  begin
    {rstn, resetPinN, emul_select_hi, emul_select_lo, coreSleep, coreHalt} = 6'h10;
    {serialDivTwo, coreMemReadN, coreMemWriteN, coreBootSelN, coreWorkSelN} = 5'h0;
    {corePeriphSelN, coreRdN, coreWrN, coreDataOe} = 4'h1;
    pin_function_select_reg = 3'h7;
    coreAddr = 20'h5A5A5;
    coreDataOut = 8'hC3;
    tick(20);
    rstn <= 1'h1;
    waitIdle(400);
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clock);
      pin_function_select_reg <= k[0] ? 3'h7 : 3'h0;
      {coreHalt, coreSleep} <= k[1] ? 2'h2 : 2'h1;
      tick(1);
      #1 chk("rd", memory_read_strobe_n, k[0]);
      chk("wr", memory_write_strobe_n, k[0]);
      chk("cs", {boot_memory_select_n, work_memory_select_n}, 2'h3);
      chk("pso", peripheral_select_oe, !k[0]);
      chk("oe", {strobeOe, addrOe, dataOe}, 3'h0);
      chk("abus", addrBus, ~coreAddr);
      chk("dbus", dataBus, 8'(~coreDataOut));
      chk("uart", uartEmulEnable, 1'h0);
      @(posedge clock);
      {coreHalt, coreSleep} <= 2'h0;
      tick(1);
      #1 chk("exit", {memory_read_strobe_n, boot_memory_select_n, addrOe}, 3'h1);
      chk("abus on", addrBus, coreAddr);
      chk("dbus on", dataBus, coreDataOut);
      chk("pins", {peripheral_select_n, readStrobeN, writeStrobeN}, {corePeriphSelN, coreRdN, coreWrN});
    end
    $display("test power-down done");
    @(posedge clock);
    serialDivTwo <= 1'h1;
    tick(2);
    #1 chk("div2", serialClkDivTwo, 1'h1);
    for (int m = 2; m >= 0; m--)
    begin
      @(posedge clock);
      {emul_select_hi, emul_select_lo} <= m[1:0];
      resetPinN <= 1'h0;
      tick(4);
      #1 chk("osc", oscEnable, m == 0);
      chk("rst", {internalReset, uartEmulEnable, serialClkDivTwo}, 3'h4);
      @(posedge clock);
      resetPinN <= 1'h1;
      tick(8);
      #1 chk("stretch", internalReset, m != 1);
      @(posedge clock);
      coreSleep <= 1'h1;
      tick(2);
      #1 chk("emul abus", addrBus, (m == 1) ? 20'h40000 : ~coreAddr);
      @(posedge clock);
      coreSleep <= 1'h0;
      waitIdle(400);
    end
    $display("test modes and reset done");
    report_and_stop();
  end
endmodule
`default_nettype wire
